// file: design/itfm_consts.svh
// Register offsets, field positions, reset values and function codes of the input map.
`ifndef ITFM_CONSTS_SVH
`define ITFM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ITFM_ADDR_ASSIGN_LO   12'h000
`define ITFM_ADDR_ASSIGN_HI   12'h004
`define ITFM_ADDR_POLARITY    12'h008
`define ITFM_ADDR_REMOTE_LO   12'h00C
`define ITFM_ADDR_REMOTE_HI   12'h010
`define ITFM_ADDR_RMASK_LO    12'h014
`define ITFM_ADDR_RMASK_HI    12'h018
`define ITFM_ADDR_FUNC_LO     12'h01C
`define ITFM_ADDR_FUNC_HI     12'h020
`define ITFM_ADDR_TERMINAL    12'h024

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define ITFM_CODE_W           6
`define ITFM_FIELD_STRIDE     8
`define ITFM_RST_ASSIGN_LO    32'h3130_0403
`define ITFM_RST_ASSIGN_HI    32'h1812_1032
`define ITFM_RST_POLARITY     8'h00
`define ITFM_RST_WORD         32'h0000_0000

// ----------------------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------------------
`define ITFM_FN_NONE          0
`define ITFM_FN_RUN_POS       1
`define ITFM_FN_RUN_NEG       2
`define ITFM_FN_HOME          3
`define ITFM_FN_POS_START     4
`define ITFM_FN_SEQ_START     5
`define ITFM_FN_JOG_POS       6
`define ITFM_FN_JOG_NEG       7
`define ITFM_FN_DIRECT_BASE   8
`define ITFM_FN_FREE          16
`define ITFM_FN_EXCITE        17
`define ITFM_FN_STOP          18
`define ITFM_FN_ALARM_RESET   24
`define ITFM_FN_PRESET        25
`define ITFM_FN_ABS_CLEAR     26
`define ITFM_FN_TOOL_UNLOCK   27
`define ITFM_FN_GENERAL_BASE  32
`define ITFM_FN_SELECT_BASE   48

// Codes that carry a function: 1-13, 16-18, 24-27, 32-53.
`define ITFM_VALID_MASK       64'h003F_FFFF_0F07_3FFE
// Functions that read as active while assigned nowhere: 17 and 27.
`define ITFM_DEFAULT_ON       64'h0000_0000_0802_0000

`endif

// file: design/itfm_pkg.sv
// Types shared by the input terminal function map.
package itfm_pkg;
	typedef logic [5:0]  itfm_code_t;
	typedef logic [63:0] itfm_func_t;
endpackage

// file: design/itfm_map_if.sv
// Interface between the register block and the terminal decoder.
`timescale 1ns/1ps
interface itfm_map_if #(parameter int NUM_TERM = 8);
	import itfm_pkg::*;
	logic [NUM_TERM-1:0] level;
	itfm_code_t          code [NUM_TERM];
	itfm_func_t          active;
	itfm_func_t          assigned;
	modport dec (input level, input code, output active, output assigned);
	modport top (output level, output code, input active, input assigned);
endinterface

// file: design/itfm_decode.sv
// Decoder from terminal levels and assignment codes to function vectors.
`timescale 1ns/1ps
module itfm_decode import itfm_pkg::*; #(
	parameter int NUM_TERM = 8
) (
	// Map side
	itfm_map_if.dec m
);
	// ------------------------------------------------------------------------
	// Per-function gathering over all terminals
	// ------------------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < 64; c++) begin : g_fn
			logic hit_act;
			logic hit_asg;
			always_comb begin
				hit_act = 1'b0;
				hit_asg = 1'b0;
				for (int t = 0; t < NUM_TERM; t++) begin
					if (m.code[t] == 6'(c)) begin
						hit_asg = 1'b1;
						hit_act = hit_act | m.level[t];
					end
				end
			end
			assign m.active[c]   = hit_act;
			assign m.assigned[c] = hit_asg;
		end
	endgenerate
endmodule

// file: design/itfm_top.sv
// APB-programmed map of eight input terminals onto motor command functions.
`timescale 1ns/1ps
`include "itfm_consts.svh"

module itfm_top import itfm_pkg::*; #(
	parameter int NUM_TERM = 8
) (
	// Clock and reset
	input  wire logic                 CLOCK_I,
	input  wire logic                 RSTN_I,
	// APB slave
	input  wire logic                 PSEL_I,
	input  wire logic                 PENABLE_I,
	input  wire logic                 PWRITE_I,
	input  wire logic [11:0]          PADDR_I,
	input  wire logic [31:0]          PWDATA_I,
	input  wire logic [3:0]           PSTRB_I,
	output logic      [31:0]          PRDATA_O,
	output logic                      PREADY_O,
	output logic                      PSLVERR_O,
	// Input terminals
	input  wire logic [NUM_TERM-1:0]  IN_TERMINAL_I,
	// Motor command functions
	output logic                      RUN_POSITIVE_O,
	output logic                      RUN_NEGATIVE_O,
	output logic                      HOME_START_O,
	output logic                      POSITION_START_O,
	output logic                      SEQUENTIAL_START_O,
	output logic                      JOG_POSITIVE_O,
	output logic                      JOG_NEGATIVE_O,
	output logic      [5:0]           DIRECT_POSITION_O,
	output logic                      FREE_O,
	output logic                      EXCITE_ON_O,
	output logic                      STOP_O,
	output logic                      ALARM_RESET_O,
	output logic                      POSITION_PRESET_O,
	output logic                      ABSOLUTE_ERROR_CLEAR_O,
	output logic                      TOOL_UNLOCK_O,
	output logic      [15:0]          GENERAL_BIT_O,
	output logic      [5:0]           DATA_SELECT_O
);

	// ------------------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------------------
	if (NUM_TERM < 1 || NUM_TERM > 8) begin : g_bad_num_term
		$error("NUM_TERM must lie between 1 and 8.");
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [31:0]         assign_lo_q;
	logic [31:0]         assign_hi_q;
	logic [7:0]          polarity_q;
	itfm_func_t          remote_q;
	itfm_func_t          rmask_q;
	itfm_func_t          func_q;
	itfm_func_t          func_d;
	logic                alarm_pulse_q;
	logic                preset_pulse_q;
	logic                clear_pulse_q;

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	wire logic           wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
	wire logic           sel_alo  = PADDR_I == `ITFM_ADDR_ASSIGN_LO;
	wire logic           sel_ahi  = PADDR_I == `ITFM_ADDR_ASSIGN_HI;
	wire logic           sel_pol  = PADDR_I == `ITFM_ADDR_POLARITY;
	wire logic           sel_rlo  = PADDR_I == `ITFM_ADDR_REMOTE_LO;
	wire logic           sel_rhi  = PADDR_I == `ITFM_ADDR_REMOTE_HI;
	wire logic           sel_mlo  = PADDR_I == `ITFM_ADDR_RMASK_LO;
	wire logic           sel_mhi  = PADDR_I == `ITFM_ADDR_RMASK_HI;
	wire logic           sel_flo  = PADDR_I == `ITFM_ADDR_FUNC_LO;
	wire logic           sel_fhi  = PADDR_I == `ITFM_ADDR_FUNC_HI;
	wire logic           sel_term = PADDR_I == `ITFM_ADDR_TERMINAL;
	wire logic           mapped   = sel_alo | sel_ahi | sel_pol | sel_rlo | sel_rhi |
	                                sel_mlo | sel_mhi | sel_flo | sel_fhi | sel_term;
	wire logic [31:0]    code_keep = 32'h3F3F_3F3F;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

	wire logic [31:0]    rd_word =
		sel_alo  ? assign_lo_q :
		sel_ahi  ? assign_hi_q :
		sel_pol  ? {24'h00_0000, polarity_q} :
		sel_rlo  ? remote_q[31:0] :
		sel_rhi  ? remote_q[63:32] :
		sel_mlo  ? rmask_q[31:0] :
		sel_mhi  ? rmask_q[63:32] :
		sel_flo  ? func_q[31:0] :
		sel_fhi  ? func_q[63:32] :
		sel_term ? {24'h00_0000, 8'(IN_TERMINAL_I)} :
		32'h0000_0000;

	assign PRDATA_O = (PSEL_I & ~PWRITE_I) ? rd_word : 32'h0000_0000;

	// ------------------------------------------------------------------------
	// Register write strobes and next values
	// ------------------------------------------------------------------------
	wire logic           wr_alo      = wr_en & sel_alo;
	wire logic           wr_ahi      = wr_en & sel_ahi;
	wire logic           wr_pol      = wr_en & sel_pol & PSTRB_I[0];
	wire logic           wr_rlo      = wr_en & sel_rlo;
	wire logic           wr_rhi      = wr_en & sel_rhi;
	wire logic           wr_mlo      = wr_en & sel_mlo;
	wire logic           wr_mhi      = wr_en & sel_mhi;
	wire logic [31:0]    assign_lo_d = merge(assign_lo_q, PWDATA_I, PSTRB_I) & code_keep;
	wire logic [31:0]    assign_hi_d = merge(assign_hi_q, PWDATA_I, PSTRB_I) & code_keep;
	wire logic [7:0]     polarity_d  = PWDATA_I[7:0];
	wire logic [31:0]    remote_lo_d = merge(remote_q[31:0], PWDATA_I, PSTRB_I);
	wire logic [31:0]    remote_hi_d = merge(remote_q[63:32], PWDATA_I, PSTRB_I);
	wire logic [31:0]    rmask_lo_d  = merge(rmask_q[31:0], PWDATA_I, PSTRB_I);
	wire logic [31:0]    rmask_hi_d  = merge(rmask_q[63:32], PWDATA_I, PSTRB_I);

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			assign_lo_q <= `ITFM_RST_ASSIGN_LO;
		end else if (wr_alo) begin
			assign_lo_q <= assign_lo_d;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			assign_hi_q <= `ITFM_RST_ASSIGN_HI;
		end else if (wr_ahi) begin
			assign_hi_q <= assign_hi_d;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			polarity_q <= `ITFM_RST_POLARITY;
		end else if (wr_pol) begin
			polarity_q <= polarity_d;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			remote_q <= {`ITFM_RST_WORD, `ITFM_RST_WORD};
		end else begin
			if (wr_rlo) begin
				remote_q[31:0] <= remote_lo_d;
			end
			if (wr_rhi) begin
				remote_q[63:32] <= remote_hi_d;
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rmask_q <= {`ITFM_RST_WORD, `ITFM_RST_WORD};
		end else begin
			if (wr_mlo) begin
				rmask_q[31:0] <= rmask_lo_d;
			end
			if (wr_mhi) begin
				rmask_q[63:32] <= rmask_hi_d;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Terminal decode
	// ------------------------------------------------------------------------
	itfm_map_if #(.NUM_TERM(NUM_TERM)) map ();

	wire logic [63:0]    codes_flat = {assign_hi_q, assign_lo_q};

	genvar t;
	generate
		for (t = 0; t < NUM_TERM; t++) begin : g_term
			assign map.code[t]  = codes_flat[8*t +: 6];
			assign map.level[t] = IN_TERMINAL_I[t] ^ polarity_q[t];
		end
	endgenerate

	itfm_decode #(.NUM_TERM(NUM_TERM)) u_decode (
		.m (map.dec)
	);

	// ------------------------------------------------------------------------
	// Source combination
	// ------------------------------------------------------------------------
	wire itfm_func_t     valid   = `ITFM_VALID_MASK;
	wire itfm_func_t     d_asg   = map.assigned & valid;
	wire itfm_func_t     r_asg   = rmask_q & valid;
	wire itfm_func_t     d_act   = map.active;
	wire itfm_func_t     r_act   = remote_q;
	wire itfm_func_t     dflt_on = `ITFM_DEFAULT_ON;

	assign func_d = ( d_asg &  r_asg & d_act & r_act) |
	                ( d_asg & ~r_asg & d_act) |
	                (~d_asg &  r_asg & r_act) |
	                (~d_asg & ~r_asg & dflt_on & valid);

	// ------------------------------------------------------------------------
	// Registered function levels
	// ------------------------------------------------------------------------
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			func_q <= {`ITFM_RST_WORD, `ITFM_RST_WORD};
		end else begin
			func_q <= func_d;
		end
	end

	// ------------------------------------------------------------------------
	// Edge pulses
	// ------------------------------------------------------------------------
	wire logic           alarm_fall  = func_q[`ITFM_FN_ALARM_RESET] &
	                                   ~func_d[`ITFM_FN_ALARM_RESET];
	wire logic           clear_fall  = func_q[`ITFM_FN_ABS_CLEAR] &
	                                   ~func_d[`ITFM_FN_ABS_CLEAR];
	wire logic           preset_rise = ~func_q[`ITFM_FN_PRESET] &
	                                   func_d[`ITFM_FN_PRESET];

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			alarm_pulse_q  <= 1'b0;
			preset_pulse_q <= 1'b0;
			clear_pulse_q  <= 1'b0;
		end else begin
			alarm_pulse_q  <= alarm_fall;
			preset_pulse_q <= preset_rise;
			clear_pulse_q  <= clear_fall;
		end
	end

	// ------------------------------------------------------------------------
	// Function outputs
	// ------------------------------------------------------------------------
	assign RUN_POSITIVE_O         = func_q[`ITFM_FN_RUN_POS];
	assign RUN_NEGATIVE_O         = func_q[`ITFM_FN_RUN_NEG];
	assign HOME_START_O           = func_q[`ITFM_FN_HOME];
	assign POSITION_START_O       = func_q[`ITFM_FN_POS_START];
	assign SEQUENTIAL_START_O     = func_q[`ITFM_FN_SEQ_START];
	assign JOG_POSITIVE_O         = func_q[`ITFM_FN_JOG_POS];
	assign JOG_NEGATIVE_O         = func_q[`ITFM_FN_JOG_NEG];
	assign DIRECT_POSITION_O      = func_q[`ITFM_FN_DIRECT_BASE +: 6];
	assign FREE_O                 = func_q[`ITFM_FN_FREE];
	assign EXCITE_ON_O            = func_q[`ITFM_FN_EXCITE];
	assign STOP_O                 = func_q[`ITFM_FN_STOP];
	assign ALARM_RESET_O          = alarm_pulse_q;
	assign POSITION_PRESET_O      = preset_pulse_q;
	assign ABSOLUTE_ERROR_CLEAR_O = clear_pulse_q;
	assign TOOL_UNLOCK_O          = func_q[`ITFM_FN_TOOL_UNLOCK];
	assign GENERAL_BIT_O          = func_q[`ITFM_FN_GENERAL_BASE +: 16];
	assign DATA_SELECT_O          = func_q[`ITFM_FN_SELECT_BASE +: 6];

endmodule

// file: tb/itfm_host_model.sv
// Host controller model that drives the eight input terminals.
`timescale 1ns/1ps
module itfm_host_model (
	// Clock
	input  wire logic       clk_i,
	// Requested terminal levels
	input  wire logic [7:0] req_i,
	// Terminal pins
	output logic      [7:0] pins_o
);
	// A host output stage changes its pins just after the rising edge.
	always @(posedge clk_i) begin
		pins_o <= req_i;
	end
endmodule

// file: tb/itfm_assertions.sv
// Concurrent checks on the ports of the input terminal map.
`timescale 1ns/1ps
module itfm_assertions (
	// Clock, reset and bus
	input wire logic        CLOCK_I,
	input wire logic        RSTN_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	// Functions
	input wire logic        HOME_START_O,
	input wire logic        RUN_POSITIVE_O,
	input wire logic        RUN_NEGATIVE_O,
	input wire logic [5:0]  DIRECT_POSITION_O,
	input wire logic        FREE_O,
	input wire logic        EXCITE_ON_O,
	input wire logic        STOP_O,
	input wire logic        TOOL_UNLOCK_O,
	input wire logic        ALARM_RESET_O,
	input wire logic        POSITION_PRESET_O,
	input wire logic        ABSOLUTE_ERROR_CLEAR_O,
	input wire logic [15:0] GENERAL_BIT_O,
	input wire logic [5:0]  DATA_SELECT_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);
	wire rd_acc  = PSEL_I && PENABLE_I && !PWRITE_I;
	wire bad_adr = PADDR_I > 12'h024 || PADDR_I[1:0] != 2'b00;
	ready_high_a: assert property (PREADY_O) else $error("pready low");
	slverr_map_a: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == bad_adr) else $error("slverr");
	idle_rdata_a: assert property (!PSEL_I || PWRITE_I |-> PRDATA_O == 32'h0000_0000) else $error("rdata");
	unmapped_read_a: assert property (rd_acc && bad_adr |-> PRDATA_O == 32'h0000_0000) else $error("unmapped");
	alarm_pulse_a: assert property (ALARM_RESET_O |=> !ALARM_RESET_O) else $error("alarm");
	preset_pulse_a: assert property (POSITION_PRESET_O |=> !POSITION_PRESET_O) else $error("preset");
	clear_pulse_a: assert property (ABSOLUTE_ERROR_CLEAR_O |=> !ABSOLUTE_ERROR_CLEAR_O) else $error("clr");
	func_lo_a: assert property (
		rd_acc && PADDR_I == 12'h01C |-> PRDATA_O[3:1] == {HOME_START_O, RUN_NEGATIVE_O,
		RUN_POSITIVE_O} && PRDATA_O[13:8] == DIRECT_POSITION_O && PRDATA_O[27] == TOOL_UNLOCK_O
		&& PRDATA_O[18:16] == {STOP_O, EXCITE_ON_O, FREE_O}) else $error("lo");
	func_hi_a: assert property (
		rd_acc && PADDR_I == 12'h020 |-> PRDATA_O[21:0] == {DATA_SELECT_O, GENERAL_BIT_O})
		else $error("hi");
	alarm_c: cover property (ALARM_RESET_O);
	preset_c: cover property (POSITION_PRESET_O);
	slverr_c: cover property (PSLVERR_O);
endmodule
bind itfm_top itfm_assertions u_chk (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .HOME_START_O(HOME_START_O),
	.RUN_POSITIVE_O(RUN_POSITIVE_O), .RUN_NEGATIVE_O(RUN_NEGATIVE_O),
	.DIRECT_POSITION_O(DIRECT_POSITION_O), .FREE_O(FREE_O), .EXCITE_ON_O(EXCITE_ON_O),
	.STOP_O(STOP_O), .TOOL_UNLOCK_O(TOOL_UNLOCK_O), .ALARM_RESET_O(ALARM_RESET_O),
	.POSITION_PRESET_O(POSITION_PRESET_O), .ABSOLUTE_ERROR_CLEAR_O(ABSOLUTE_ERROR_CLEAR_O),
	.GENERAL_BIT_O(GENERAL_BIT_O), .DATA_SELECT_O(DATA_SELECT_O));

// file: tb/tb_input_terminal_function_map.sv
// Self-checking bench for the input terminal function map.
`timescale 1ns/1ps
`include "itfm_consts.svh"
module tb_input_terminal_function_map;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [7:0]  req, pins;
	logic [5:0]  direct, dsel;
	logic [15:0] gen;
	logic        rp, rn, home, pos, sq, jp, jn, free, exc, stop, alm, pre, clr, unl;
	int          n_errors, checks_done, n_pulse;
	itfm_host_model host (.clk_i(clk), .req_i(req), .pins_o(pins));
	itfm_top dut (.CLOCK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IN_TERMINAL_I(pins),
		.RUN_POSITIVE_O(rp), .RUN_NEGATIVE_O(rn), .HOME_START_O(home),
		.POSITION_START_O(pos), .SEQUENTIAL_START_O(sq), .JOG_POSITIVE_O(jp),
		.JOG_NEGATIVE_O(jn), .DIRECT_POSITION_O(direct), .FREE_O(free), .EXCITE_ON_O(exc),
		.STOP_O(stop), .ALARM_RESET_O(alm), .POSITION_PRESET_O(pre),
		.ABSOLUTE_ERROR_CLEAR_O(clr), .TOOL_UNLOCK_O(unl), .GENERAL_BIT_O(gen),
		.DATA_SELECT_O(dsel));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Pulses are weighted so that each pulse output is told apart.
	always @(posedge clk) begin
		n_pulse <= n_pulse + int'(alm) + 2 * int'(pre) + 4 * int'(clr);
	end
	task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		chk("pready", 1'b1, pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pin(input logic [7:0] v);
		@(posedge clk);
		req <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task t_reset;
		apb(1'b0, `ITFM_ADDR_ASSIGN_LO, 32'h0000_0000, 4'h0);
		chk("assign_lo", 32'h3130_0403, rd);
		apb(1'b0, `ITFM_ADDR_ASSIGN_HI, 32'h0000_0000, 4'h0);
		chk("assign_hi", 32'h1812_1032, rd);
		apb(1'b0, `ITFM_ADDR_POLARITY, 32'h0000_0000, 4'h0);
		chk("polarity", 32'h0000_0000, rd);
		apb(1'b0, 12'h100, 32'h0000_0000, 4'h0);
		chk("unmapped", 33'h1_0000_0000, {er, rd});
	endtask
	task t_levels;
		pin(8'h00);
		chk("idle", 16'h0003, {stop, free, home, pos, alm, exc, unl});
		pin(8'h01);
		chk("home", 1'b1, home);
		pin(8'h02);
		chk("start", 1'b1, pos);
		pin(8'h60);
		chk("free_stop", 2'b11, {free, stop});
		pin(8'h1C);
		chk("select", 6'h07, dsel);
		apb(1'b0, `ITFM_ADDR_TERMINAL, 32'h0000_0000, 4'h0);
		chk("terminal", 32'h0000_001C, rd);
		pin(8'h00);
	endtask
	task t_codes;
		logic [63:0] f, e, o;
		logic        v;
		for (int c = 0; c < 64; c++) begin
			v = (c >= 1 && c <= 13) || (c >= 16 && c <= 18) || (c >= 24 && c <= 27)
				|| (c >= 32 && c <= 53);
			apb(1'b1, `ITFM_ADDR_ASSIGN_LO, {24'h00_0000, 2'b11, 6'(c)}, 4'hF);
			for (int p = 1; p >= 0; p--) begin
				pin(8'(p));
				apb(1'b0, `ITFM_ADDR_FUNC_LO, 32'h0000_0000, 4'h0);
				f[31:0] = rd;
				apb(1'b0, `ITFM_ADDR_FUNC_HI, 32'h0000_0000, 4'h0);
				f[63:32] = rd;
				e = 64'h0000_0000_0802_0000;
				if (v)
					e[c] = p[0];
				chk("func", e, f);
				o = 64'h0000_0000_0000_0000;
				o[7:1] = {jn, jp, sq, pos, home, rn, rp};
				o[13:8] = direct;
				o[18:16] = {stop, exc, free};
				o[27] = unl;
				o[53:32] = {dsel, gen};
				chk("outputs", e & ~64'h0000_0000_0700_0000, o);
			end
		end
		apb(1'b0, `ITFM_ADDR_ASSIGN_LO, 32'h0000_0000, 4'h0);
		chk("code_bits", 32'h0000_003F, rd);
	endtask
	task t_edges;
		int p0;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `ITFM_ADDR_ASSIGN_LO, 32'h0000_0018 + 32'(i), 4'hF);
			p0 = n_pulse;
			pin(8'h01);
			chk("rise", i == 1 ? 2 : 0, n_pulse - p0);
			p0 = n_pulse;
			pin(8'h00);
			chk("fall", i == 0 ? 1 : (i == 2 ? 4 : 0), n_pulse - p0);
		end
	endtask
	task t_remote;
		apb(1'b1, `ITFM_ADDR_ASSIGN_LO, 32'h0000_0001, 4'hF);
		apb(1'b1, `ITFM_ADDR_RMASK_LO, 32'h0000_0006, 4'hF);
		apb(1'b1, `ITFM_ADDR_REMOTE_LO, 32'h0000_0004, 4'hF);
		pin(8'h01);
		chk("dual_remote", 2'b10, {rn, rp});
		apb(1'b1, `ITFM_ADDR_REMOTE_LO, 32'h0000_0006, 4'hF);
		pin(8'h01);
		chk("dual_both", 2'b11, {rn, rp});
		apb(1'b1, `ITFM_ADDR_RMASK_LO, 32'h0000_0000, 4'hF);
		pin(8'h00);
	endtask
	task t_or_pol;
		apb(1'b1, `ITFM_ADDR_ASSIGN_LO, 32'hFFFF_0303, 4'h3);
		apb(1'b0, `ITFM_ADDR_ASSIGN_LO, 32'h0000_0000, 4'h0);
		chk("strobe", 32'h0000_0303, rd);
		pin(8'h02);
		chk("or_home", 1'b1, home);
		apb(1'b1, `ITFM_ADDR_POLARITY, 32'hFFFF_FF01, 4'hF);
		apb(1'b0, `ITFM_ADDR_POLARITY, 32'h0000_0000, 4'h0);
		chk("pol_read", 32'h0000_0001, rd);
		pin(8'h00);
		chk("pol_low", 1'b1, home);
		pin(8'h01);
		chk("pol_high", 1'b0, home);
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100_000;
		n_errors++;
		wrap_up;
	end
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		req = 8'h00;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_levels;
		t_codes;
		t_edges;
		t_remote;
		t_or_pol;
		wrap_up;
	end
endmodule
